//--- rtl/sarseq_top.sv
// sar converter sequencer: apb registers, mode control, divider, result
`timescale 1ns/1ns
`default_nettype none
`include "sarseq_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// overview
//
// five registers sit behind the apb port, one aligned word each:
//   status/control  channel, reference select, reference level, irq
//                   enable, completion flag (read only)
//   main control    prescaler extra divide, power-up bit
//   pin enable      plain storage, mirrored on a port
//   result high     upper two bits of the last finished code
//   result low      lower eight bits of the last finished code
//
// only the low byte of a write is used; reads return zero above the
// bits that a register holds. an unmapped address answers with an
// error in the access phase, drops a write and reads as zero.
//
// the slave never inserts wait states: pready is tied high, so every
// transfer is one setup and one access cycle.
//
// read data is captured at the end of the setup cycle. this keeps
// prdata a flop output at the cost of showing the register contents
// one cycle before the access edge; a completion landing in that one
// cycle is seen on the next read.
//
////////////////////////////////////////////////////////////////////////////////
// conversion sequence
//
// a status/control write while powered up starts a conversion at the
// access edge. the divider restarts with it, so the first conversion
// clock tick falls a full tick period later and every conversion has
// the same timing whatever the phase of the bus write.
//
// for an input channel the sampler opens its window and the sar arms.
// after the fixed number of ticks the sampler hands over to the sar,
// which decides one bit per tick, most significant first. the end of
// conversion pulse from the sar is the only thing that marks a
// conversion done: the code is copied into the result and the flag set.
//
// for a reference conversion the sampler stays idle and the channel
// switches stay open; the sar loads all zeros or all ones and reports
// done at the next tick.
//
////////////////////////////////////////////////////////////////////////////////
// aborts and power-down
//
// any write to status/control, main control or pin enable drops what
// is running. the status/control write then starts again at once; the
// other two leave the block idle. clearing the power-up bit holds the
// abort for as long as the bit stays low and holds the divider at zero.
//
// an aborted conversion leaves the previous result in place and does
// not set the flag. the registers stay readable and writable while
// powered down, but a status/control write then stores its fields
// without starting anything.
//
// limitation: the comparator is sampled at conversion ticks only, so
// the analog side must settle within one tick period of a code change.
//
////////////////////////////////////////////////////////////////////////////////

module sarseq_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     cmp_in,
  output sarseq_pkg::sarseq_code_t      dac_code,
  output logic      [7:0]               chan_connect,
  output logic      [7:0]               pin_enable,
  output logic                          sample_clk_en,
  output logic                          analog_power_up,
  output logic                          conv_irq
);
  import sarseq_pkg::*;

  sarseq_if link ();

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic acc, wr, rd;
  logic hit_sc, hit_mc, hit_pe, hit_rh, hit_rl, mapped;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;

  // address decode, unmapped addresses answer with an error
  always_comb begin
    hit_sc = 1'b0;
    hit_mc = 1'b0;
    hit_pe = 1'b0;
    hit_rh = 1'b0;
    hit_rl = 1'b0;
    if (paddr == `SARSEQ_OFS_STATUS_CTRL) begin
      hit_sc = 1'b1;
    end else if (paddr == `SARSEQ_OFS_MAIN_CTRL) begin
      hit_mc = 1'b1;
    end else if (paddr == `SARSEQ_OFS_PIN_ENABLE) begin
      hit_pe = 1'b1;
    end else if (paddr == `SARSEQ_OFS_RESULT_HIGH) begin
      hit_rh = 1'b1;
    end else if (paddr == `SARSEQ_OFS_RESULT_LOW) begin
      hit_rl = 1'b1;
    end
  end

  assign mapped = hit_sc | hit_mc | hit_pe | hit_rh | hit_rl;
  assign pready = 1'b1; // zero wait states
  assign pslverr = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // registers and mode control
  logic [6:0]   sc_q, sc_d;      // status/control without the flag
  logic         ccf_q, ccf_d;
  logic [7:0]   mc_q, mc_d;
  logic [7:0]   pe_q, pe_d;
  sarseq_code_t res_q, res_d;
  sarseq_ctl_e  ctl_q, ctl_d;
  logic [7:0]   oh_q, oh_d;
  logic [31:0]  rdata_q, rdata_d;
  logic         power_up;
  logic         start, kill;

  assign power_up = mc_q[`SARSEQ_MC_POWER_UP];
  // a start also discards what was running; sub-machines let it win
  assign start = wr & hit_sc & power_up;
  assign kill = (wr & (hit_sc | hit_mc | hit_pe)) | ~power_up;

  always_comb begin
    sc_d = sc_q;
    mc_d = mc_q;
    pe_d = pe_q;
    ccf_d = ccf_q;
    res_d = res_q;
    ctl_d = ctl_q;
    oh_d = oh_q;
    // registers are writable even while powered down
    if (wr & hit_sc) begin
      sc_d = pwdata[6:0];
    end
    if (wr & hit_mc) begin
      mc_d = pwdata[7:0];
    end
    if (wr & hit_pe) begin
      pe_d = pwdata[7:0];
    end
    // clears first so that a completion in the same cycle as a result read still sets
    if ((wr & hit_sc) | (rd & (hit_rh | hit_rl))) begin
      ccf_d = 1'b0;
    end
    if (start) begin
      ctl_d = CTL_BUSY;
      oh_d = 8'h00;
      if (!pwdata[`SARSEQ_SC_REF_SEL]) begin
        oh_d[pwdata[2:0]] = 1'b1;
      end
    end else if (kill) begin
      ctl_d = CTL_IDLE;
      oh_d = 8'h00;
    end else if (ctl_q == CTL_BUSY && link.eoc) begin
      ctl_d = CTL_IDLE;
      oh_d = 8'h00;
      res_d = link.code;
      ccf_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_q <= 7'(`SARSEQ_RST_SC);
      mc_q <= `SARSEQ_RST_MC;
      pe_q <= `SARSEQ_RST_PE;
      ccf_q <= 1'b0;
      res_q <= 10'h000;
      ctl_q <= CTL_IDLE;
      oh_q <= 8'h00;
    end else begin
      sc_q <= sc_d;
      mc_q <= mc_d;
      pe_q <= pe_d;
      ccf_q <= ccf_d;
      res_q <= res_d;
      ctl_q <= ctl_d;
      oh_q <= oh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase from the registers
  always_comb begin
    rdata_d = rdata_q;
    if (psel & ~penable & ~pwrite) begin
      rdata_d = 32'h0000_0000;
      if (paddr == `SARSEQ_OFS_STATUS_CTRL) begin
        rdata_d[7:0] = {ccf_q, sc_q};
      end else if (paddr == `SARSEQ_OFS_MAIN_CTRL) begin
        rdata_d[7:0] = mc_q;
      end else if (paddr == `SARSEQ_OFS_PIN_ENABLE) begin
        rdata_d[7:0] = pe_q;
      end else if (paddr == `SARSEQ_OFS_RESULT_HIGH) begin
        rdata_d[1:0] = res_q[9:8];
      end else if (paddr == `SARSEQ_OFS_RESULT_LOW) begin
        rdata_d[7:0] = res_q[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock divider: base divide keeps the rate at or below the
  // maximum, the prescaler only slows it further
  logic [11:0] div_q, div_d;
  logic [11:0] div_last;
  logic        tick_q, tick_d;

  assign div_last = 12'((`SARSEQ_CONV_DIV) * (32'(mc_q[3:0]) + 32'd1) - 1);

  always_comb begin
    div_d = div_q;
    tick_d = 1'b0;
    if (!power_up || start) begin
      div_d = 12'h000;
    end else if (div_q >= div_last) begin
      div_d = 12'h000;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hand-off to the sub-machines
  assign link.tick = tick_q & power_up;
  assign link.abort = kill;
  assign link.sh_start = start & ~pwdata[`SARSEQ_SC_REF_SEL];
  assign link.sar_prep = start & ~pwdata[`SARSEQ_SC_REF_SEL];
  assign link.ref_load = start & pwdata[`SARSEQ_SC_REF_SEL];
  assign link.ref_high = pwdata[`SARSEQ_SC_REF_HIGH];

  sarseq_sh u_sh (
    .pclk          (pclk),
    .presetn       (presetn),
    .bus           (link),
    .sample_clk_en (sample_clk_en)
  );

  sarseq_sar u_sar (
    .pclk     (pclk),
    .presetn  (presetn),
    .bus      (link),
    .cmp_in   (cmp_in),
    .dac_code (dac_code)
  );

  assign prdata = rdata_q;
  assign chan_connect = oh_q;
  assign pin_enable = pe_q;
  assign analog_power_up = power_up;
  assign conv_irq = ccf_q & sc_q[`SARSEQ_SC_IRQ_EN];
endmodule
`default_nettype wire

//--- rtl/sarseq_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SARSEQ_REGS_SVH
`define SARSEQ_REGS_SVH
`define SARSEQ_OFS_STATUS_CTRL 12'h000
`define SARSEQ_OFS_MAIN_CTRL   12'h004
`define SARSEQ_OFS_PIN_ENABLE  12'h008
`define SARSEQ_OFS_RESULT_HIGH 12'h00C
`define SARSEQ_OFS_RESULT_LOW  12'h010
`define SARSEQ_SC_CHAN_LSB     0
`define SARSEQ_SC_REF_SEL      3
`define SARSEQ_SC_REF_HIGH     4
`define SARSEQ_SC_IRQ_EN       6
`define SARSEQ_SC_CCF          7
`define SARSEQ_MC_PRESC_LSB    0
`define SARSEQ_MC_POWER_UP     7
`define SARSEQ_RST_SC          8'h00
`define SARSEQ_RST_MC          8'h00
`define SARSEQ_RST_PE          8'h00
`define SARSEQ_CLK_KHZ         250000
`define SARSEQ_CONV_MAX_KHZ    2000
`define SARSEQ_CONV_DIV ((`SARSEQ_CLK_KHZ + `SARSEQ_CONV_MAX_KHZ - 1) / `SARSEQ_CONV_MAX_KHZ)
`define SARSEQ_SAMPLE_TICKS    14
`define SARSEQ_RES_BITS        10
`define SARSEQ_NUM_CHAN        8
`endif

//--- rtl/sarseq_pkg.sv
// types shared by the sequencer modules
package sarseq_pkg;
  typedef enum logic [0:0] {CTL_IDLE, CTL_BUSY} sarseq_ctl_e;
  typedef enum logic [0:0] {SH_IDLE, SH_SAMPLE} sarseq_sh_e;
  typedef enum logic [1:0] {SAR_IDLE, SAR_ARMED, SAR_RUN, SAR_REF} sarseq_sar_e;
  typedef logic [9:0] sarseq_code_t;
  typedef logic [2:0] sarseq_chan_t;
endpackage

//--- rtl/sarseq_if.sv
// handshakes between mode control, sample-and-hold and sar machine
`timescale 1ns/1ns
`default_nettype none
interface sarseq_if;
  import sarseq_pkg::*;
  logic         tick;      // conversion clock enable
  logic         abort;     // drop any conversion
  logic         sh_start;  // begin acquiring
  logic         sar_prep;  // sar: prepare for a sample
  logic         ref_load;  // sar: load a reference itself
  logic         ref_high;  // which reference
  logic         sar_go;    // sampling over, convert
  logic         eoc;       // end of conversion pulse
  sarseq_code_t code;      // finished code
  modport ctl (output tick, abort, sh_start, sar_prep, ref_load, ref_high,
               input eoc, code);
  modport sh  (input tick, abort, sh_start, output sar_go);
  modport sar (input tick, abort, sar_prep, ref_load, ref_high, sar_go,
               output eoc, code);
endinterface
`default_nettype wire

//--- rtl/sarseq_sh.sv
// sample-and-hold machine: fixed sampling window, gates its clock when idle
`timescale 1ns/1ns
`default_nettype none
`include "sarseq_regs.svh"
module sarseq_sh (
  input  wire logic pclk,
  input  wire logic presetn,
  sarseq_if.sh      bus,
  output logic      sample_clk_en
);
  import sarseq_pkg::*;

  sarseq_sh_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic       go_q, go_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state: count ticks of the window, then hand over to the sar
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    go_d = 1'b0;
    if (bus.sh_start) begin
      st_d = SH_SAMPLE;
      cnt_d = 4'h0;
    end else if (bus.abort) begin
      st_d = SH_IDLE;
    end else if (st_q == SH_SAMPLE && bus.tick) begin
      if (cnt_q == 4'(`SARSEQ_SAMPLE_TICKS - 1)) begin
        st_d = SH_IDLE;
        go_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SH_IDLE;
      cnt_q <= 4'h0;
      go_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      go_q <= go_d;
    end
  end

  assign bus.sar_go = go_q;
  // internal clocks run only inside the window, saving power otherwise
  assign sample_clk_en = (st_q == SH_SAMPLE);
endmodule
`default_nettype wire

//--- rtl/sarseq_sar.sv
// sar machine: binary search against the comparator, or reference load
`timescale 1ns/1ns
`default_nettype none
`include "sarseq_regs.svh"
module sarseq_sar (
  input  wire logic          pclk,
  input  wire logic          presetn,
  sarseq_if.sar              bus,
  input  wire logic          cmp_in,
  output sarseq_pkg::sarseq_code_t dac_code
);
  import sarseq_pkg::*;

  sarseq_sar_e  st_q, st_d;
  sarseq_code_t sar_q, sar_d;
  logic [3:0]   bit_q, bit_d;
  logic         eoc_q, eoc_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state: one bit decided per conversion clock tick
  always_comb begin
    st_d = st_q;
    sar_d = sar_q;
    bit_d = bit_q;
    eoc_d = 1'b0;
    if (bus.ref_load) begin
      st_d = SAR_REF;
      sar_d = bus.ref_high ? 10'h3FF : 10'h000;
    end else if (bus.sar_prep) begin
      st_d = SAR_ARMED;
      sar_d = 10'h000;
    end else if (bus.abort) begin
      st_d = SAR_IDLE;
    end else begin
      case (st_q)
        SAR_ARMED: begin
          // only runs once sampling is over, never beside it
          if (bus.sar_go) begin
            st_d = SAR_RUN;
            bit_d = 4'(`SARSEQ_RES_BITS - 1);
            sar_d = 10'h200;
          end
        end
        SAR_RUN: begin
          if (bus.tick) begin
            if (!cmp_in) begin
              sar_d[bit_q] = 1'b0;
            end
            if (bit_q == 4'h0) begin
              st_d = SAR_IDLE;
              eoc_d = 1'b1;
            end else begin
              bit_d = bit_q - 4'h1;
              sar_d[bit_q - 4'h1] = 1'b1;
            end
          end
        end
        SAR_REF: begin
          if (bus.tick) begin
            st_d = SAR_IDLE;
            eoc_d = 1'b1;
          end
        end
        default: begin
          st_d = SAR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SAR_IDLE;
      sar_q <= 10'h000;
      bit_q <= 4'h0;
      eoc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sar_q <= sar_d;
      bit_q <= bit_d;
      eoc_q <= eoc_d;
    end
  end

  assign bus.eoc = eoc_q;
  assign bus.code = sar_q;
  assign dac_code = sar_q;
endmodule
`default_nettype wire

//--- dv/sarseq_properties.sv
// port-level assertions for the sar sequencer top
`timescale 1ns/1ns
`default_nettype none
module sarseq_properties (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire sarseq_pkg::sarseq_code_t dac_code,
  input wire logic [7:0]               chan_connect,
  input wire logic                     sample_clk_en,
  input wire logic                     analog_power_up,
  input wire logic                     conv_irq
);
  logic        wr;
  logic        sc_wr;
  logic        ab_wr;
  logic        rd_res;
  logic [2:0]  ch_q;
  logic [3:0]  pr_q;
  logic [15:0] win_q;
  logic [15:0] lim;
  //////////////////////////////////////////////////////////////////////////////
  // decoded bus events; the window limit follows the prescaler last written
  assign wr = psel && penable && pwrite;
  assign sc_wr = wr && paddr == 12'h000;
  assign ab_wr = wr && (paddr == 12'h004 || paddr == 12'h008);
  assign rd_res = psel && penable && !pwrite && (paddr == 12'h00C || paddr == 12'h010);
  assign lim = 16'd1750 * ({12'h0, pr_q} + 16'h1);
  // channel of the last bus cycle and length of the current sampling window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_q <= 3'h0;
      pr_q <= 4'h0;
      win_q <= 16'h0;
    end else begin
      ch_q <= pwdata[2:0];
      if (wr && paddr == 12'h004) begin
        pr_q <= pwdata[3:0];
      end
      // a restart opens a fresh window, so the count starts over with it
      win_q <= (sample_clk_en && !sc_wr) ? win_q + 16'h1 : 16'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chan_onehot_a: assert property ($onehot0(chan_connect))
    else $error("more than one channel connected");
  start_sample_a: assert property (sc_wr && analog_power_up && !pwdata[3]
    |=> sample_clk_en && chan_connect == 8'h01 << ch_q) else $error("conversion did not start");
  abort_stop_a: assert property (ab_wr |=> !sample_clk_en && chan_connect == 8'h00)
    else $error("control write did not abort");
  ref_skip_a: assert property (sc_wr && pwdata[3] |=> !sample_clk_en && chan_connect == 8'h00)
    else $error("reference conversion used the sampler");
  pwr_down_a: assert property (!analog_power_up |=> !sample_clk_en && chan_connect == 8'h00)
    else $error("sampling while powered down");
  sample_hold_a: assert property (sample_clk_en && $past(sample_clk_en) |-> $stable(dac_code))
    else $error("sar moved during sampling");
  busy_noflag_a: assert property (sample_clk_en |-> !conv_irq)
    else $error("complete before conversion");
  flag_clear_a: assert property (rd_res |=> !conv_irq)
    else $error("result read left flag set");
  abort_noflag_a: assert property (ab_wr && !conv_irq |=> (!conv_irq) [*8])
    else $error("aborted conversion set flag");
  win_max_a: assert property (sample_clk_en |-> win_q <= lim)
    else $error("sampling window too long");
  win_min_a: assert property ($fell(sample_clk_en) && !$past(wr) |-> win_q + 16'h1 >= lim)
    else $error("sampling window too short");
  cover property (sc_wr && pwdata[3]);
  cover property ($rose(conv_irq));
  cover property (ab_wr && sample_clk_en);
endmodule
bind sarseq_top sarseq_properties sarseq_properties_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .dac_code, .chan_connect, .sample_clk_en, .analog_power_up,
  .conv_irq);
`default_nettype wire

//--- dv/sar_adc_sequencer_tb_top.sv
// self-checking bench for the sar sequencer
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer_tb_top;
  import sarseq_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, cmp_in, err;
  logic         pready, pslverr, sample_clk_en, analog_power_up, conv_irq;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, hi, seed;
  logic [7:0]   chan_connect, pin_enable;
  logic [9:0]   vin;
  sarseq_code_t dac_code;
  int           bad_count, num_checks, cyc, win;
  sarseq_top sarseq_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmp_in, .dac_code, .chan_connect, .pin_enable,
    .sample_clk_en, .analog_power_up, .conv_irq);
  //////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ideal comparator plus hang guard; the ceiling is about twice the planned run
  always @(posedge pclk) begin
    cmp_in <= vin >= dac_code;
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      final_report;
    end
  end
  // counted at the falling edge so the window length never races the design
  always @(negedge pclk) begin
    if (sample_clk_en === 1'b1) win++;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, then one idle cycle so strobes never toggle twice at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // start a conversion, wait for completion, read and compare the result
  task automatic conv(input logic [7:0] sc, input logic [9:0] exp);
    apb(1'b1, 12'h000, {24'h0, sc});
    // cleared after the write so a window cut by this restart is not counted
    win = 0;
    chk(32'(chan_connect), sc[3] ? 0 : 32'h1 << sc[2:0]);
    repeat (6000) if (conv_irq !== 1'b1) @(posedge pclk);
    chk(32'(conv_irq), 1);
    chk(32'(sc[3] ? win == 0 : win > 1748 && win < 1752), 1);
    apb(1'b0, 12'h00C, 0);
    hi = rd;
    apb(1'b0, 12'h010, 0);
    chk({22'h0, hi[1:0], rd[7:0]}, {22'h0, exp});
    chk(32'(hi[31:2]) | 32'(rd[31:8]), 0);
    chk(32'(conv_irq), 0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, cmp_in, presetn, paddr, pwdata, vin} = '0;
    seed = 32'h41DAE64D;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and the unmapped place
    for (int a = 0; a < 6; a++) begin
      apb(1'b0, 12'(4 * a), 0);
      chk({rd[31:1], err}, 32'(a == 5));
    end
    chk(32'(analog_power_up), 0);
    apb(1'b1, 12'h004, 32'h80);
    $display("test reset done");
    // every channel with a random level, then both references
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      vin <= seed[9:0];
      conv(8'h40 | 8'(c), seed[9:0]);
    end
    conv(8'h48, 10'h000);
    conv(8'h58, 10'h3FF);
    $display("test channels done");
    // aborts by main control, pin enable and power-down keep the old result
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 12'h000, 32'h43);
      repeat (500) @(posedge pclk);
      apb(1'b1, k == 1 ? 12'h008 : 12'h004, k == 0 ? 32'h80 : 32'h3C);
      chk(32'(sample_clk_en), 0);
      repeat (4000) @(posedge pclk);
      chk(32'(conv_irq), 0);
      apb(1'b0, 12'h010, 0);
      chk(rd, 32'hFF);
    end
    chk(32'(pin_enable), 32'h3C);
    apb(1'b1, 12'h000, 32'h41);
    chk(32'(sample_clk_en), 0);
    apb(1'b1, 12'h004, 32'h80);
    $display("test aborts done");
    // restart mid-sampling on another channel
    seed = lfsr(seed);
    vin <= seed[9:0];
    apb(1'b1, 12'h000, 32'h42);
    repeat (900) @(posedge pclk);
    conv(8'h45, seed[9:0]);
    $display("test restart done");
    final_report;
  end
endmodule
`default_nettype wire
